/* src/lcdri_core.sv */
`timescale 1ns/1ps
`include "lcdri_cfg.svh"

// Function
// - Hardware init: display off, normal polarity
// - Hardware init: segment order normal
// - Hardware init: power control cleared
// - Hardware init: serial shift state cleared
// - Hardware init: 1/9 bias, n-line off, no powersave
// - Hardware init: all-lit off, oscillator stopped
// - Init: static indicator off, register zero
// - Init: read-modify-write off, test mode off
// - Init: start line at first line
// - Init: column and page pointers zero
// - Init: common scan normal, ratio zero
// - Init: contrast mode ended, contrast mid
// - Init: n-line reversal register zero
// - Soft reset applies only the subset
// - Discharge drive nodes while init low
// - Classify cycles from select and strobes
// - Commands run on internal clock only
// - Command AF on, AE off
// - Display off drives outputs to VDD
// - Status reset flag during soft reset countdown only
module lcdri_core
    import lcdri_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Host bus pins
    input  wire logic        init_in_n,
    input  wire logic        cs_n,
    input  wire logic        cmd_data_select,
    input  wire logic        rd_e,
    input  wire logic        wr_rw,
    input  wire logic [7:0]  db_in,
    output logic      [7:0]  db_out,
    output logic             db_oe,
    input  wire logic        sclk,
    input  wire logic        sdi,
    // Display side
    input  wire logic [7:0]  ram_rdata,
    output logic             disp_wr,
    output logic             disp_rd,
    output logic      [7:0]  disp_wdata,
    output lcdri_ctl_t       ctl,
    output logic             drivers_to_vdd,
    output logic             discharge_en,
    output logic             resetting
);

    // ----------------------------------------------------------------
    // State and decode signals
    // ----------------------------------------------------------------
    lcdri_st_t              r;
    lcdri_st_t              n;
    logic                   arst_n;
    logic [`LCDRI_PINW-1:0] pin_vec;
    logic [`LCDRI_PINW-1:0] pin_flt;
    logic                   busy;
    logic                   rd_now;
    logic                   rd_was;
    logic                   par_wr;
    logic                   ser_edge;
    logic                   ser_done;
    logic                   byte_v;
    logic [7:0]             byte_d;
    logic                   is_data;
    logic                   srst_ev;
    logic [7:0]             status;
    logic                   apb_setup;
    logic                   apb_acc;

    // Whole state held while init pin is low
    assign arst_n  = presetn & init_in_n;
    assign pin_vec = {cs_n, cmd_data_select, rd_e, wr_rw, sclk, sdi, db_in};

    // ----------------------------------------------------------------
    // Pin filter: change taken when stages two and three agree
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `LCDRI_PINW; gi++) begin : g_flt
            assign pin_flt[gi] = (r.s2[gi] == r.s3[gi]) ? r.s3[gi] : r.filt[gi];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Host cycle classification
    // ----------------------------------------------------------------
    function automatic logic rd_active(input logic [`LCDRI_PINW-1:0] p, input logic m68, input logic ser);
        logic act;
        act = 1'b0;
        if (!ser && !p[`LCDRI_P_CSN]) begin
            if (m68) begin
                act = p[`LCDRI_P_RDE] & p[`LCDRI_P_WRRW];
            end else begin
                act = ~p[`LCDRI_P_RDE];
            end
        end
        return act;
    endfunction

    assign rd_now = rd_active(r.filt, r.bus68, r.serial);
    assign rd_was = rd_active(r.filt_d, r.bus68, r.serial);

    // Write ends on the trailing strobe edge
    assign par_wr = !r.serial && !r.filt_d[`LCDRI_P_CSN] &&
                    (r.bus68 ? (r.filt_d[`LCDRI_P_RDE] && !r.filt[`LCDRI_P_RDE] && !r.filt_d[`LCDRI_P_WRRW])
                             : (!r.filt_d[`LCDRI_P_WRRW] && r.filt[`LCDRI_P_WRRW]));

    assign ser_edge = r.serial && !r.filt[`LCDRI_P_CSN] &&
                      !r.filt_d[`LCDRI_P_SCLK] && r.filt[`LCDRI_P_SCLK];
    assign ser_done = ser_edge && (r.bitcnt == 3'h7);

    assign byte_v  = r.serial ? ser_done : par_wr;
    assign byte_d  = r.serial ? {r.sh[6:0], r.filt[`LCDRI_P_SDI]} : r.filt_d[7:0];
    assign is_data = r.filt_d[`LCDRI_P_CD];
    assign busy    = (r.srst_cnt != 3'h0);
    assign srst_ev = byte_v && !busy && !is_data && (r.mode == LCDRI_M_IDLE) && (byte_d == `LCDRI_C_RESET);

    always_comb begin
        status                   = 8'h00;
        status[`LCDRI_STS_BUSY]  = busy;
        status[`LCDRI_STS_ADC]   = ~r.ctl.adc_rev;
        status[`LCDRI_STS_ONOFF] = ~r.ctl.display_on;
        status[`LCDRI_STS_RESET] = busy;
    end

    assign apb_setup = psel && !penable;
    assign apb_acc   = psel && penable;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        n         = r;
        n.s1      = pin_vec;
        n.s2      = r.s1;
        n.s3      = r.s2;
        n.filt    = pin_flt;
        n.filt_d  = r.filt;
        n.disp_wr = 1'b0;
        n.disp_rd = 1'b0;

        // Serial bit count cleared whenever chip select drops away or serial mode is off; shift register kept
        if (r.filt[`LCDRI_P_CSN] || !r.serial) begin
            n.bitcnt = 3'h0;
        end else if (ser_edge) begin
            n.sh     = {r.sh[6:0], r.filt[`LCDRI_P_SDI]};
            n.bitcnt = r.bitcnt + 3'h1;
        end

        if (busy) begin
            n.srst_cnt = r.srst_cnt - 3'h1;
        end

        // Command and data writes, run on pclk
        if (byte_v && !busy) begin
            if (is_data) begin
                n.disp_wr = 1'b1;
                n.wdata   = byte_d;
                if (r.ctl.col != `LCDRI_COL_MAX) begin
                    n.ctl.col = r.ctl.col + 8'h01;
                end
            end else if (r.mode == LCDRI_M_CONTRAST) begin
                n.ctl.contrast = byte_d[5:0];
                n.mode         = LCDRI_M_IDLE;
            end else if (r.mode == LCDRI_M_INDIC) begin
                n.ctl.ind_reg = byte_d[1:0];
                n.mode        = LCDRI_M_IDLE;
            end else if ({byte_d[7:1], 1'b0} == `LCDRI_C_DISP) begin
                n.ctl.display_on = byte_d[0];
            end else if ({byte_d[7:6], 6'h00} == `LCDRI_C_START) begin
                n.ctl.start_line = byte_d[5:0];
            end else if ({byte_d[7:4], 4'h0} == `LCDRI_C_PAGE) begin
                n.ctl.page = byte_d[3:0];
            end else if ({byte_d[7:4], 4'h0} == `LCDRI_C_COLHI) begin
                n.ctl.col[7:4] = byte_d[3:0];
            end else if ({byte_d[7:4], 4'h0} == `LCDRI_C_COLLO) begin
                n.ctl.col[3:0] = byte_d[3:0];
            end else if ({byte_d[7:1], 1'b0} == `LCDRI_C_ADC) begin
                n.ctl.adc_rev = byte_d[0];
            end else if ({byte_d[7:1], 1'b0} == `LCDRI_C_REV) begin
                n.ctl.reverse = byte_d[0];
            end else if ({byte_d[7:1], 1'b0} == `LCDRI_C_ALLON) begin
                n.ctl.all_on = byte_d[0];
            end else if ({byte_d[7:1], 1'b0} == `LCDRI_C_BIAS) begin
                n.ctl.bias_7 = byte_d[0];
            end else if (byte_d == `LCDRI_C_OSC) begin
                n.ctl.osc_on = 1'b1;
            end else if ({byte_d[7:1], 1'b0} == `LCDRI_C_IND) begin
                n.ctl.ind_on = byte_d[0];
                n.mode       = LCDRI_M_INDIC;
            end else if (byte_d == `LCDRI_C_CONTRAST) begin
                n.mode = LCDRI_M_CONTRAST;
            end else if (byte_d == `LCDRI_C_RMW) begin
                n.ctl.rmw = 1'b1;
                n.rmw_col = r.ctl.col;
            end else if (byte_d == `LCDRI_C_END) begin
                n.ctl.rmw = 1'b0;
                n.ctl.col = r.rmw_col;
            end else if ({byte_d[7:4], 4'h0} == `LCDRI_C_COM) begin
                n.ctl.com_rev = byte_d[3];
            end else if ({byte_d[7:3], 3'h0} == `LCDRI_C_POWER) begin
                n.ctl.power = byte_d[2:0];
            end else if ({byte_d[7:3], 3'h0} == `LCDRI_C_RATIO) begin
                n.ctl.ratio = byte_d[2:0];
            end else if (srst_ev) begin
                // Subset only; display, power, bias, oscillator kept
                n.ctl.ind_on     = 1'b0;
                n.ctl.ind_reg    = 2'h0;
                n.ctl.rmw        = 1'b0;
                n.ctl.start_line = 6'h00;
                n.ctl.col        = 8'h00;
                n.ctl.page       = 4'h0;
                n.ctl.com_rev    = 1'b0;
                n.ctl.ratio      = 3'h0;
                n.ctl.contrast   = `LCDRI_CONTRAST_RST;
                n.mode           = LCDRI_M_IDLE;
                n.ctl.nline_reg  = 4'h0;
                n.ctl.test_mode  = 1'b0;
                n.srst_cnt       = 3'(`LCDRI_SRST_CYC);
            end
        end

        // Reads: status or display data captured at strobe start
        if (rd_now && !rd_was) begin
            if (r.filt[`LCDRI_P_CD]) begin
                n.db_out  = ram_rdata;
                n.disp_rd = 1'b1;
            end else begin
                n.db_out = status;
            end
        end
        if (!rd_now && rd_was && r.filt_d[`LCDRI_P_CD] && !busy && !r.ctl.rmw &&
            (r.ctl.col != `LCDRI_COL_MAX)) begin
            n.ctl.col = r.ctl.col + 8'h01;
        end

        n.ctl.contrast_mode = (n.mode == LCDRI_M_CONTRAST);

        // APB: read data and error taken in setup, write at access
        if (apb_setup) begin
            n.prdata  = 32'h0000_0000;
            n.pslverr = 1'b0;
            case (paddr)
                `LCDRI_OFS_CFG: begin
                    n.prdata[`LCDRI_CFG_BUS68]  = r.bus68;
                    n.prdata[`LCDRI_CFG_SERIAL] = r.serial;
                    n.prdata[`LCDRI_CFG_NLON]   = r.ctl.nline_on;
                    n.prdata[`LCDRI_CFG_TEST]   = r.ctl.test_mode;
                    n.prdata[`LCDRI_CFG_NLREG]  = r.ctl.nline_reg;
                end
                `LCDRI_OFS_STATUS: begin
                    n.prdata[7:0] = status;
                end
                `LCDRI_OFS_CTL_LO: begin
                    n.prdata = r.ctl[31:0];
                end
                `LCDRI_OFS_CTL_HI: begin
                    n.prdata[15:0] = r.ctl[47:32];
                end
                default: begin
                    n.pslverr = 1'b1;
                end
            endcase
        end
        if (apb_acc && pwrite && (paddr == `LCDRI_OFS_CFG)) begin
            n.bus68         = pwdata[`LCDRI_CFG_BUS68];
            n.serial        = pwdata[`LCDRI_CFG_SERIAL];
            n.ctl.nline_on  = pwdata[`LCDRI_CFG_NLON];
            n.ctl.test_mode = pwdata[`LCDRI_CFG_TEST];
            n.ctl.nline_reg = pwdata[`LCDRI_CFG_NLREG];
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge arst_n) begin
        if (!arst_n) begin
            r              <= '0;
            r.s1           <= `LCDRI_PIN_IDLE;
            r.s2           <= `LCDRI_PIN_IDLE;
            r.s3           <= `LCDRI_PIN_IDLE;
            r.filt         <= `LCDRI_PIN_IDLE;
            r.filt_d       <= `LCDRI_PIN_IDLE;
            r.ctl.contrast <= `LCDRI_CONTRAST_RST;
            r.mode         <= LCDRI_M_IDLE;
        end else begin
            r <= n;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata         = r.prdata;
    assign pslverr        = r.pslverr;
    assign pready         = apb_acc;
    assign db_out         = r.db_out;
    assign db_oe          = rd_now;
    assign disp_wr        = r.disp_wr;
    assign disp_rd        = r.disp_rd;
    assign disp_wdata     = r.wdata;
    assign ctl            = r.ctl;
    assign drivers_to_vdd = ~r.ctl.display_on;
    assign discharge_en   = ~init_in_n;
    assign resetting      = ~init_in_n | busy;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic fresh_r;
    always_ff @(posedge pclk or negedge arst_n) begin
        if (!arst_n) begin
            fresh_r <= 1'b1;
        end else begin
            fresh_r <= 1'b0;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!arst_n);

    a_init_display: assert property (fresh_r |-> !ctl.display_on && !ctl.reverse && drivers_to_vdd)
        else $error("display not off and normal after init");
    a_init_power: assert property (fresh_r |-> ctl.power == 3'h0 && !ctl.bias_7 && !ctl.adc_rev)
        else $error("power, bias or segment order wrong after init");
    a_init_osc: assert property (fresh_r |-> !ctl.osc_on && !ctl.all_on && !ctl.nline_on)
        else $error("oscillator or all-lit not cleared after init");
    a_init_contrast: assert property (fresh_r |-> ctl.contrast == 6'h20 && !ctl.contrast_mode)
        else $error("contrast not mid value after init");
    a_disp_on_cmd: assert property (byte_v && !busy && !is_data && r.mode == LCDRI_M_IDLE &&
                                    byte_d == 8'hAF |=> ctl.display_on && !drivers_to_vdd)
        else $error("display on command missed");
    a_disp_off_cmd: assert property (byte_v && !busy && !is_data && r.mode == LCDRI_M_IDLE &&
                                     byte_d == 8'hAE |=> !ctl.display_on)
        else $error("display off command missed");
    a_soft_subset: assert property (srst_ev |=> ctl.col == 8'h00 && ctl.page == 4'h0 &&
                                    ctl.start_line == 6'h00 && ctl.contrast == 6'h20 &&
                                    ctl.display_on == $past(ctl.display_on) &&
                                    ctl.power == $past(ctl.power))
        else $error("soft reset subset wrong");
    a_soft_flag: assert property (srst_ev |=> resetting [*4] ##1 !resetting)
        else $error("resetting flag length wrong");
    a_oe_select: assert property (db_oe |-> !r.filt[`LCDRI_P_CSN] && !r.serial)
        else $error("data bus driven without select");
    a_col_sat: assert property (byte_v && !busy && is_data && ctl.col == 8'hFF |=> ctl.col == 8'hFF)
        else $error("column passed its limit");

    c_soft_reset: cover property (srst_ev);
    c_serial_byte: cover property (ser_done && !busy);
    c_status_read: cover property (rd_now && !rd_was && !r.filt[`LCDRI_P_CD]);
    c_apb_error: cover property (apb_acc && pslverr);

endmodule

/* src/lcdri_cfg.svh */
`ifndef LCDRI_CFG_SVH
`define LCDRI_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LCDRI_OFS_CFG     12'h000
`define LCDRI_OFS_STATUS  12'h004
`define LCDRI_OFS_CTL_LO  12'h008
`define LCDRI_OFS_CTL_HI  12'h00C

// ----------------------------------------------------------------
// Config register fields
// ----------------------------------------------------------------
`define LCDRI_CFG_BUS68   0
`define LCDRI_CFG_SERIAL  1
`define LCDRI_CFG_NLON    2
`define LCDRI_CFG_TEST    3
`define LCDRI_CFG_NLREG   7:4

// ----------------------------------------------------------------
// Status byte fields
// ----------------------------------------------------------------
`define LCDRI_STS_BUSY    7
`define LCDRI_STS_ADC     6
`define LCDRI_STS_ONOFF   5
`define LCDRI_STS_RESET   4

// ----------------------------------------------------------------
// Host pin vector layout and idle level
// ----------------------------------------------------------------
`define LCDRI_PINW        14
`define LCDRI_P_SDI       8
`define LCDRI_P_SCLK      9
`define LCDRI_P_WRRW      10
`define LCDRI_P_RDE       11
`define LCDRI_P_CD        12
`define LCDRI_P_CSN       13
`define LCDRI_PIN_IDLE    14'h2C00

// ----------------------------------------------------------------
// Reset values and command codes
// ----------------------------------------------------------------
`define LCDRI_CONTRAST_RST 6'h20
`define LCDRI_COL_MAX      8'hFF
`define LCDRI_C_DISP       8'hAE
`define LCDRI_C_START      8'h40
`define LCDRI_C_PAGE       8'hB0
`define LCDRI_C_COLHI      8'h10
`define LCDRI_C_COLLO      8'h00
`define LCDRI_C_ADC        8'hA0
`define LCDRI_C_REV        8'hA6
`define LCDRI_C_ALLON      8'hA4
`define LCDRI_C_BIAS       8'hA2
`define LCDRI_C_RMW        8'hE0
`define LCDRI_C_END        8'hEE
`define LCDRI_C_RESET      8'hE2
`define LCDRI_C_COM        8'hC0
`define LCDRI_C_POWER      8'h28
`define LCDRI_C_RATIO      8'h20
`define LCDRI_C_CONTRAST   8'h81
`define LCDRI_C_IND        8'hAC
`define LCDRI_C_OSC        8'hAB

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LCDRI_CLK_NS      25
`define LCDRI_SRST_NS     100
`define LCDRI_SRST_CYC    ((`LCDRI_SRST_NS + `LCDRI_CLK_NS - 1) / `LCDRI_CLK_NS)

`endif

/* src/lcdri_pkg.sv */
`include "lcdri_cfg.svh"

package lcdri_pkg;

    typedef enum logic [1:0] {
        LCDRI_M_IDLE     = 2'h0,
        LCDRI_M_CONTRAST = 2'h1,
        LCDRI_M_INDIC    = 2'h3
    } lcdri_mode_t;

    typedef struct packed {
        logic       display_on;
        logic       reverse;
        logic       adc_rev;
        logic       all_on;
        logic       bias_7;
        logic [2:0] power;
        logic       osc_on;
        logic       ind_on;
        logic [1:0] ind_reg;
        logic       rmw;
        logic [5:0] start_line;
        logic [7:0] col;
        logic [3:0] page;
        logic       com_rev;
        logic [2:0] ratio;
        logic [5:0] contrast;
        logic       contrast_mode;
        logic       nline_on;
        logic [3:0] nline_reg;
        logic       test_mode;
    } lcdri_ctl_t;

    typedef struct packed {
        logic [`LCDRI_PINW-1:0] s1;
        logic [`LCDRI_PINW-1:0] s2;
        logic [`LCDRI_PINW-1:0] s3;
        logic [`LCDRI_PINW-1:0] filt;
        logic [`LCDRI_PINW-1:0] filt_d;
        lcdri_ctl_t             ctl;
        lcdri_mode_t            mode;
        logic [7:0]             rmw_col;
        logic [2:0]             srst_cnt;
        logic [7:0]             sh;
        logic [2:0]             bitcnt;
        logic [7:0]             db_out;
        logic                   disp_wr;
        logic                   disp_rd;
        logic [7:0]             wdata;
        logic                   bus68;
        logic                   serial;
        logic [31:0]            prdata;
        logic                   pslverr;
    } lcdri_st_t;

endpackage

/* testbench/lcdri_host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Host processor, both parallel styles and serial
// ----------------------------------------
module lcdri_host_model (
    // Clock
    input  wire logic pclk,
    // Host pins
    output logic       cs_n,
    output logic       cmd_data_select,
    output logic       rd_e,
    output logic       wr_rw,
    output logic [7:0] db_in,
    output logic       sclk,
    output logic       sdi,
    // Host read-back
    input  wire logic [7:0] db_out,
    input  wire logic       db_oe
);
    initial begin
        cs_n = 1'b1;
        cmd_data_select = 1'b0;
        rd_e = 1'b1;
        wr_rw = 1'b1;
        db_in = 8'h00;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    task automatic pw(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic wr80(input logic cd, input logic [7:0] b);
        cs_n <= 1'b0;
        cmd_data_select <= cd;
        db_in <= b;
        pw(5);
        wr_rw <= 1'b0;
        pw(5);
        wr_rw <= 1'b1;
        pw(5);
        cs_n <= 1'b1;
        db_in <= ~b;
        pw(1);
    endtask
    task automatic wr68(input logic cd, input logic [7:0] b);
        cs_n <= 1'b0;
        cmd_data_select <= cd;
        db_in <= b;
        wr_rw <= 1'b0;
        rd_e <= 1'b0;
        pw(5);
        rd_e <= 1'b1;
        pw(5);
        rd_e <= 1'b0;
        pw(5);
        cs_n <= 1'b1;
        wr_rw <= 1'b1;
        rd_e <= 1'b1;
        pw(1);
    endtask
    task automatic rd80(input logic cd, output logic [7:0] q, output logic oe);
        cs_n <= 1'b0;
        cmd_data_select <= cd;
        pw(5);
        rd_e <= 1'b0;
        pw(8);
        q = db_out;
        oe = db_oe;
        rd_e <= 1'b1;
        pw(5);
        cs_n <= 1'b1;
        pw(1);
    endtask
    task automatic ser(input logic cd, input logic [7:0] b);
        cs_n <= 1'b0;
        cmd_data_select <= cd;
        for (int i = 7; i >= 0; i--) begin
            sdi <= b[i];
            pw(5);
            sclk <= 1'b1;
            pw(5);
            sclk <= 1'b0;
        end
        pw(5);
        cs_n <= 1'b1;
        sdi <= ~b[0];
        pw(1);
    endtask
endmodule

/* testbench/tb_lcdri_core.sv */
`timescale 1ns/1ps
module tb_lcdri_core
    import lcdri_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        init_in_n = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, er, db_oe, disp_wr, disp_rd;
    logic        cs_n, cmd_data_select, rd_e, wr_rw, sclk, sdi;
    logic        drivers_to_vdd, discharge_en, resetting;
    logic [7:0]  db_in, db_out, disp_wdata;
    logic [7:0]  ram_rdata = 8'h00;
    lcdri_ctl_t  ctl, exp;
    logic [7:0]  rb, n_wr = 8'h00, n_rd = 8'h00;
    logic        ob;
    int          fail_count = 0, check_count = 0, cyc = 0;

    always #12.5 pclk = ~pclk;

    lcdri_core u_lcdri_core (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .init_in_n, .cs_n, .cmd_data_select, .rd_e, .wr_rw,
        .db_in, .db_out, .db_oe, .sclk, .sdi, .ram_rdata, .disp_wr, .disp_rd, .disp_wdata,
        .ctl, .drivers_to_vdd, .discharge_en, .resetting);
    lcdri_host_model u_lcdri_host_model (.pclk, .cs_n, .cmd_data_select, .rd_e, .wr_rw,
        .db_in, .sclk, .sdi, .db_out, .db_oe);

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic pw(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input string nm, input logic [47:0] s, input logic [47:0] e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic init_exp();
        exp = '0;
        exp.contrast = 6'h20;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        init_exp();
        chk("ctl", ctl, exp);
        chk("vdd", drivers_to_vdd, 1'b1);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk("status", rd, 32'h0000_0060);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk("unmapped", er, 1'b1);
        $display("reset values done");
    endtask
    task automatic t_cmd();
        u_lcdri_host_model.wr80(1'b0, 8'hAF);
        pw(10);
        chk("disp on", ctl.display_on, 1'b1);
        chk("vdd", drivers_to_vdd, 1'b0);
        u_lcdri_host_model.wr80(1'b1, 8'h3C);
        pw(10);
        chk("wdata", disp_wdata, 8'h3C);
        chk("col", ctl.col, 8'h01);
        chk("wr pulses", n_wr, 8'h01);
        ram_rdata <= 8'h5A;
        u_lcdri_host_model.rd80(1'b0, rb, ob);
        chk("status rd", rb, 8'h40);
        chk("oe during rd", ob, 1'b1);
        chk("oe after rd", db_oe, 1'b0);
        u_lcdri_host_model.rd80(1'b1, rb, ob);
        chk("data rd", rb, 8'h5A);
        chk("col rd", ctl.col, 8'h02);
        chk("rd pulses", n_rd, 8'h01);
        apb(1'b1, 12'h000, 32'h0000_0001);
        u_lcdri_host_model.wr68(1'b0, 8'hB5);
        pw(10);
        chk("page 68", ctl.page, 4'h5);
        $display("commands done");
    endtask
    task automatic t_soft();
        logic [7:0] q [5];
        q = '{8'hA1, 8'hA3, 8'hB3, 8'h81, 8'h05};
        apb(1'b1, 12'h000, 32'h0000_0002);
        foreach (q[i]) u_lcdri_host_model.ser(1'b0, q[i]);
        u_lcdri_host_model.wr80(1'b0, 8'hA7);
        pw(10);
        chk("adc", ctl.adc_rev, 1'b1);
        chk("page", ctl.page, 4'h3);
        chk("contrast", ctl.contrast, 6'h05);
        chk("reverse", ctl.reverse, 1'b0);
        u_lcdri_host_model.ser(1'b0, 8'hE2);
        pw(20);
        init_exp();
        exp.display_on = 1'b1;
        exp.adc_rev = 1'b1;
        exp.bias_7 = 1'b1;
        chk("soft ctl", ctl, exp);
        apb(1'b1, 12'h000, 32'h0000_0000);
        $display("soft reset done");
    endtask
    task automatic t_hw();
        apb(1'b1, 12'h000, 32'h0000_00F4);
        pw(1);
        chk("nline", ctl.nline_reg, 4'hF);
        u_lcdri_host_model.wr80(1'b0, 8'hAE);
        pw(10);
        chk("disp off", ctl.display_on, 1'b0);
        chk("vdd off", drivers_to_vdd, 1'b1);
        init_in_n <= 1'b0;
        pw(3);
        chk("discharge", discharge_en, 1'b1);
        chk("resetting", resetting, 1'b1);
        u_lcdri_host_model.wr80(1'b0, 8'hAF);
        init_exp();
        chk("held ctl", ctl, exp);
        init_in_n <= 1'b1;
        pw(10);
        chk("rel ctl", ctl, exp);
        chk("discharge", discharge_en, 1'b0);
        chk("resetting", resetting, 1'b0);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk("cfg", rd, 32'h0000_0000);
        $display("hardware init done");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (disp_wr) n_wr <= n_wr + 8'h01;
        if (disp_rd) n_rd <= n_rd + 8'h01;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end

    initial begin
        pw(3);
        presetn <= 1'b1;
        pw(6);
        t_reset();
        t_cmd();
        t_soft();
        t_hw();
        summarize();
    end
endmodule
